// File: src/mn_pkg.sv
// Shared constants for the memory node and its configurator
`default_nettype none
package mn_pkg;
   // ------------------------------------------------------------
   // Node register window
   // ------------------------------------------------------------
   localparam logic [31:0] CSR_BASE = 32'h2180_0000;
   localparam logic [31:0] NODE_STRIDE = 32'h0000_8000;
   localparam int NODE_OFF_W = 15;
   localparam logic [7:0] OFF_IDENT = 8'h00;
   localparam logic [7:0] OFF_BUS_ERR = 8'h04;
   localparam logic [7:0] OFF_MEMORY_CONTROL_ONE = 8'h14;
   localparam logic [7:0] OFF_ECC_STAT = 8'h18;
   localparam logic [7:0] OFF_ECC_LOC = 8'h1c;
   localparam logic [7:0] OFF_MEMORY_CONTROL_TWO = 8'h30;
   localparam logic [7:0] OFF_TESTER = 8'h34;
   localparam logic [7:0] OFF_BS_ECC = 8'h38;
   localparam logic [7:0] OFF_BS_LOC = 8'h3c;
   localparam logic [7:0] OFF_RANGE_START = 8'h50;
   localparam logic [7:0] OFF_RANGE_END = 8'h54;
   localparam logic [7:0] OFF_INTERLEAVE = 8'h58;
   localparam logic [7:0] OFF_MEMORY_CONTROL_THREE = 8'h5c;
   localparam logic [7:0] OFF_MEMORY_CONTROL_FOUR = 8'h60;
   localparam logic [7:0] OFF_BS_CTL = 8'h68;
   localparam logic [7:0] OFF_BS_PTR = 8'h6c;
   localparam logic [7:0] OFF_NV_CTL = 8'h70;
   localparam logic [7:0] OFF_TIMEOUT = 8'h74;
   // One bit per word index: implemented, and writable
   localparam logic [31:0] CSR_MAP = 32'h3df0_f0e3;
   localparam logic [31:0] CSR_WRITABLE = 32'h3df0_7062;
   localparam logic [31:0] CSR_RESET = 32'h0000_0000;
   // Arbitrary identity value
   localparam logic [31:0] DEV_IDENT = 32'h0000_5a5a;
   // ------------------------------------------------------------
   // Interleave field layout and address granules
   // ------------------------------------------------------------
   localparam int ILV_POS_LSB = 5;
   localparam int ILV_POS_W = 3;
   localparam int ILV_CNT_LSB = 0;
   localparam int ILV_CNT_W = 2;
   localparam int RANGE_SHIFT = 18;
   localparam int HEXWORD_SHIFT = 5;
   // ------------------------------------------------------------
   // Transfer sizes and self-test
   // ------------------------------------------------------------
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_WORD = 2'h1;
   localparam logic [1:0] SIZE_LONG = 2'h2;
   localparam int ST_WORDS = 64;
   localparam int ST_IDX_W = 6;
   localparam logic [31:0] ST_PATTERN = 32'ha5c3_0f96;
   // ------------------------------------------------------------
   // Configurator APB map
   // ------------------------------------------------------------
   localparam logic [7:0] APB_CTRL = 8'h00;
   localparam logic [7:0] APB_NODE = 8'h04;
   localparam logic [7:0] APB_DENSITY = 8'h08;
   localparam logic [7:0] APB_SET = 8'h0c;
   localparam logic [7:0] APB_RAW_ADDR = 8'h10;
   localparam logic [7:0] APB_RAW_WDATA = 8'h14;
   localparam logic [7:0] APB_RAW_RDATA = 8'h18;
   localparam logic [7:0] APB_STATUS = 8'h1c;
   localparam logic [7:0] APB_NEXT_START = 8'h20;
   localparam int CTRL_CONFIG = 0;
   localparam int CTRL_SELFTEST = 1;
   localparam int CTRL_RAW = 2;
   localparam int CTRL_RAW_WRITE = 3;
   localparam int CTRL_CLEAR_CHAIN = 4;
   localparam int CTRL_BAD_PARITY = 5;
   localparam int CTRL_SIZE_LSB = 6;
   localparam int SET_CNT_LSB = 0;
   localparam int SET_POS_LSB = 5;
endpackage : mn_pkg
`default_nettype wire

// File: src/mn_link_if.sv
// Link between the memory node and its configuring party
`default_nettype none
interface mn_link_if;
   logic req_valid;
   logic req_write;
   logic [1:0] req_size;
   logic [31:0] req_addr;
   logic [31:0] req_wdata;
   logic req_wpar;
   logic req_ready;
   logic rsp_valid;
   logic rsp_err;
   logic [31:0] rsp_rdata;
   logic st_req;
   logic st_done;
   logic st_fail;
   modport node (
      input req_valid, req_write, req_size, req_addr, req_wdata, req_wpar,
      input st_req,
      output req_ready, rsp_valid, rsp_err, rsp_rdata, st_done, st_fail
   );
   modport host (
      output req_valid, req_write, req_size, req_addr, req_wdata, req_wpar,
      output st_req,
      input req_ready, rsp_valid, rsp_err, rsp_rdata, st_done, st_fail
   );
endinterface : mn_link_if
`default_nettype wire

// File: src/mn_selftest.sv
// Array initialise and march test engine of the memory node
`default_nettype none
module mn_selftest
   import mn_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Control
   input wire logic start,
   output logic busy,
   output logic finish,
   output logic fail
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WRITE = 3'b010,
      ST_READ = 3'b100
   } mn_st_e;

   logic [31:0] arr [ST_WORDS];
   mn_st_e state_reg, state_next;
   logic [ST_IDX_W-1:0] idx_reg, idx_next;
   logic fail_reg, fail_next;
   logic fin_reg, fin_next;
   logic [31:0] pattern;

   assign pattern = 32'(idx_reg) ^ ST_PATTERN;
   assign busy = (state_reg != ST_IDLE);
   assign finish = fin_reg;
   assign fail = fail_reg;

   // ------------------------------------------------------------
   // Sequencer: write every location, then read every one back
   // ------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      idx_next = idx_reg;
      fail_next = fail_reg;
      fin_next = 1'b0;
      case (state_reg)
         ST_IDLE:
         begin
            if (start)
            begin
               state_next = ST_WRITE;
               idx_next = '0;
               fail_next = 1'b0;
            end
         end
         ST_WRITE:
         begin
            idx_next = idx_reg + 1'b1;
            if (idx_reg == ST_IDX_W'(ST_WORDS - 1))
               state_next = ST_READ;
         end
         ST_READ:
         begin
            idx_next = idx_reg + 1'b1;
            if (arr[idx_reg] != pattern) // R08
               fail_next = 1'b1;
            if (idx_reg == ST_IDX_W'(ST_WORDS - 1))
            begin
               state_next = ST_IDLE;
               fin_next = 1'b1;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg <= ST_IDLE;
         idx_reg <= '0;
         fail_reg <= 1'b0;
         fin_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         fail_reg <= fail_next;
         fin_reg <= fin_next;
      end
   end

   // Storage has no reset; the write pass defines it before any read
   always_ff @(posedge clk)
   begin
      if (state_reg == ST_WRITE)
         arr[idx_reg] <= pattern;
   end
endmodule : mn_selftest
`default_nettype wire

// File: src/mn_node.sv
// Memory node: register bank, self-test control and address decode
// Summary of operation
// R01 - Range and interleave work in hexword units; range here counts 256 KB granules (RANGE_SHIFT)
// R02 - Console writes start, end, interleave
// R03 - End equals start plus density times factor
// R04 - First start zero, next starts at end
// R05 - Interleave bits 7:5 position, 1:0 count
// R06 - Count 01 means two; position 000 first
// R07 - Self-test at power-up and on request
// R08 - Self-test checks array, resets registers
// R09 - Failed node configured alone, bad addresses unused; here no address is excluded, a failed node still claims its whole range
// R10 - Self-test done lights yellow indicator
// R11 - Boot processor loads ranges after self-test
// R12 - Registers are 32 bits wide
// R13 - Only longword accesses reach registers
// R14 - Register writes are always full width
// R15 - Parity error aborts write, registers unchanged
// R16 - Base is fixed base plus node times stride
// R17 - Claim memory cycle on range and interleave
`default_nettype none
module mn_node
   import mn_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Link to the configuring party
   mn_link_if.node lnk,
   // Strap
   input wire logic [3:0] node_id,
   // Memory cycle decode
   input wire logic mem_valid,
   input wire logic [31:0] mem_addr,
   output logic mem_hit,
   // Indicator
   output logic st_led
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [31:0] csr_reg [32];
   logic [31:0] csr_next [32];
   logic rsp_valid_reg, rsp_valid_next;
   logic rsp_err_reg, rsp_err_next;
   logic [31:0] rsp_rdata_reg, rsp_rdata_next;
   logic por_reg, por_next;
   logic done_reg, done_next;
   logic fail_reg, fail_next;
   logic st_busy;
   logic st_finish;
   logic st_bad;
   logic st_start;
   logic [31:0] base;
   logic [NODE_OFF_W-1:0] offset;
   logic [4:0] idx;
   logic in_node;
   logic mapped;
   logic par_ok;
   logic long_ok;
   logic take;
   logic acc_ok;
   logic do_write;
   logic [31:0] unit;
   logic [31:0] hexword;
   logic [31:0] ilv_cnt;
   logic [31:0] ilv_sel;
   logic [31:0] ilv_reg;

   // ------------------------------------------------------------
   // Self-test engine
   // ------------------------------------------------------------
   // Power-up start comes from a flag that is set by reset itself
   assign st_start = (por_reg | lnk.st_req) & ~st_busy; // R07

   mn_selftest u_selftest (
      .clk(clk),
      .nrst(nrst),
      .start(st_start),
      .busy(st_busy),
      .finish(st_finish),
      .fail(st_bad)
   );

   always_comb
   begin
      por_next = 1'b0;
      done_next = done_reg;
      fail_next = fail_reg;
      if (st_start)
      begin
         done_next = 1'b0;
         fail_next = 1'b0;
      end
      else if (st_finish)
      begin
         done_next = 1'b1; // R10
         fail_next = st_bad;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         por_reg <= 1'b1;
         done_reg <= 1'b0;
         fail_reg <= 1'b0;
      end
      else
      begin
         por_reg <= por_next;
         done_reg <= done_next;
         fail_reg <= fail_next;
      end
   end

   assign st_led = done_reg; // R10
   assign lnk.st_done = done_reg;
   assign lnk.st_fail = fail_reg;

   // ------------------------------------------------------------
   // Register access decode
   // ------------------------------------------------------------
   assign base = CSR_BASE + 32'(32'(node_id) * NODE_STRIDE); // R16
   assign offset = lnk.req_addr[NODE_OFF_W-1:0];
   assign idx = offset[6:2];
   assign in_node = (lnk.req_addr[31:NODE_OFF_W] == base[31:NODE_OFF_W]); // R16
   assign mapped = (offset[NODE_OFF_W-1:7] == '0) && (offset[1:0] == 2'h0)
      && CSR_MAP[idx];
   // Odd parity over data and parity bit
   assign par_ok = ^{lnk.req_wdata, lnk.req_wpar};
   assign long_ok = (lnk.req_size == SIZE_LONG); // R13
   // Accesses wait while the array is under test
   assign lnk.req_ready = ~st_busy;
   assign take = lnk.req_valid & lnk.req_ready & in_node;
   assign acc_ok = mapped & long_ok & (~lnk.req_write | par_ok); // R13 R15
   // A write always replaces the whole word; there are no lane enables
   assign do_write = take & lnk.req_write & acc_ok; // R14

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < 32; i++)
      begin
         csr_next[i] = csr_reg[i];
         if (st_start)
            csr_next[i] = CSR_RESET; // R08
         else if (do_write && (idx == 5'(i)) && CSR_WRITABLE[i])
            csr_next[i] = lnk.req_wdata; // R12 R15
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < 32; i++)
            csr_reg[i] <= CSR_RESET;
      end
      else
      begin
         for (int i = 0; i < 32; i++)
            csr_reg[i] <= csr_next[i];
      end
   end

   // ------------------------------------------------------------
   // Response
   // ------------------------------------------------------------
   always_comb
   begin
      rsp_valid_next = take;
      rsp_err_next = take & ~acc_ok; // R13 R15
      rsp_rdata_next = rsp_rdata_reg;
      if (take && !lnk.req_write)
      begin
         if (!acc_ok)
            rsp_rdata_next = '0;
         else if (idx == OFF_IDENT[6:2])
            rsp_rdata_next = DEV_IDENT;
         else
            rsp_rdata_next = csr_reg[idx];
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rsp_valid_reg <= 1'b0;
         rsp_err_reg <= 1'b0;
         rsp_rdata_reg <= '0;
      end
      else
      begin
         rsp_valid_reg <= rsp_valid_next;
         rsp_err_reg <= rsp_err_next;
         rsp_rdata_reg <= rsp_rdata_next;
      end
   end

   assign lnk.rsp_valid = rsp_valid_reg;
   assign lnk.rsp_err = rsp_err_reg;
   assign lnk.rsp_rdata = rsp_rdata_reg;

   // ------------------------------------------------------------
   // Memory cycle claim
   // ------------------------------------------------------------
   // Range registers count in granules; interleave steps per hexword
   assign ilv_reg = csr_reg[OFF_INTERLEAVE[6:2]];
   assign unit = mem_addr >> RANGE_SHIFT;
   assign hexword = mem_addr >> HEXWORD_SHIFT; // R01
   assign ilv_cnt = 32'(ilv_reg[ILV_CNT_LSB +: ILV_CNT_W]) + 32'h1; // R05 R06
   assign ilv_sel = hexword % ilv_cnt;
   assign mem_hit = mem_valid & done_reg & ~st_busy
      & (unit >= csr_reg[OFF_RANGE_START[6:2]])
      & (unit < csr_reg[OFF_RANGE_END[6:2]])
      & (ilv_sel[ILV_POS_W-1:0] == ilv_reg[ILV_POS_LSB +: ILV_POS_W]); // R17
endmodule : mn_node
`default_nettype wire

// File: src/mn_host.sv
// Configuring party: APB slave that programs memory nodes over the link
//
// Decided for this implementation: register access over APB.
`default_nettype none
module mn_host
   import mn_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link to the node
   mn_link_if.host lnk
);
   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_STWAIT = 4'b0010,
      H_SEND = 4'b0100,
      H_RESP = 4'b1000
   } mn_hst_e;

   mn_hst_e state_reg, state_next;
   logic [1:0] step_reg, step_next;
   logic cfg_reg, cfg_next;
   logic [3:0] node_reg, node_next;
   logic [31:0] dens_reg, dens_next;
   logic [7:0] set_reg, set_next;
   logic [31:0] raw_addr_reg, raw_addr_next;
   logic [31:0] raw_wdata_reg, raw_wdata_next;
   logic [31:0] raw_rdata_reg, raw_rdata_next;
   logic [31:0] chain_reg, chain_next;
   logic [31:0] end_reg, end_next;
   logic [7:0] ctrl_reg, ctrl_next;
   logic err_reg, err_next;
   logic [31:0] a_reg, a_next;
   logic [31:0] d_reg, d_next;
   logic w_reg, w_next;
   logic p_reg, p_next;
   logic [1:0] sz_reg, sz_next;
   logic [31:0] prdata_next;
   logic [31:0] base;
   logic [2:0] factor;
   logic [2:0] pos;
   logic wr;
   logic rd;
   logic known;
   logic [31:0] ilv_word;

   assign base = CSR_BASE + 32'(32'(node_reg) * NODE_STRIDE);
   // A failed node is interleaved alone
   assign factor = (lnk.st_fail || set_reg[SET_CNT_LSB +: 3] == 3'h0)
      ? 3'h1 : set_reg[SET_CNT_LSB +: 3]; // R09
   assign pos = lnk.st_fail ? 3'h0 : set_reg[SET_POS_LSB +: 3]; // R09
   assign ilv_word = 32'({pos, 3'h0, 2'(factor - 3'h1)}); // R05 R06
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~pwrite;
   assign known = (paddr <= APB_NEXT_START) && (paddr[1:0] == 2'h0);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~known;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      step_next = step_reg;
      cfg_next = cfg_reg;
      chain_next = chain_reg;
      end_next = end_reg;
      err_next = err_reg;
      raw_rdata_next = raw_rdata_reg;
      ctrl_next = ctrl_reg;
      a_next = a_reg;
      d_next = d_reg;
      w_next = w_reg;
      p_next = p_reg;
      sz_next = sz_reg;
      lnk.st_req = 1'b0;
      case (state_reg)
         H_IDLE:
         begin
            if (wr && paddr == APB_CTRL)
            begin
               ctrl_next = pwdata[7:0];
               if (pwdata[CTRL_CLEAR_CHAIN])
                  chain_next = '0; // R04
               if (pwdata[CTRL_SELFTEST])
               begin
                  lnk.st_req = 1'b1;
                  cfg_next = pwdata[CTRL_CONFIG];
                  state_next = H_STWAIT;
               end
               else if (pwdata[CTRL_CONFIG])
               begin
                  cfg_next = 1'b1;
                  state_next = H_STWAIT; // R11
               end
               else if (pwdata[CTRL_RAW])
               begin
                  cfg_next = 1'b0;
                  step_next = 2'h3;
                  state_next = H_SEND;
                  a_next = base + 32'(raw_addr_reg[NODE_OFF_W-1:0]);
                  d_next = raw_wdata_reg;
                  w_next = pwdata[CTRL_RAW_WRITE];
                  p_next = ~^raw_wdata_reg ^ pwdata[CTRL_BAD_PARITY];
                  sz_next = pwdata[CTRL_SIZE_LSB +: 2];
               end
            end
         end
         H_STWAIT:
         begin
            if (lnk.st_done)
            begin
               if (cfg_reg)
               begin
                  // Ranges are loaded only once self-test is over
                  step_next = 2'h0; // R11
                  end_next = chain_reg + 32'(dens_reg * 32'(factor)); // R03
                  a_next = base + 32'(OFF_RANGE_START);
                  d_next = chain_reg; // R02 R04
                  w_next = 1'b1;
                  p_next = ~^chain_reg;
                  sz_next = SIZE_LONG; // R14
                  state_next = H_SEND;
               end
               else
                  state_next = H_IDLE;
            end
         end
         H_SEND:
         begin
            if (lnk.req_ready)
               state_next = H_RESP;
         end
         H_RESP:
         begin
            if (lnk.rsp_valid)
            begin
               err_next = lnk.rsp_err;
               if (!w_reg)
                  raw_rdata_next = lnk.rsp_rdata;
               state_next = H_IDLE;
               if (cfg_reg && step_reg == 2'h0)
               begin
                  step_next = 2'h1;
                  a_next = base + 32'(OFF_RANGE_END);
                  d_next = end_reg; // R02
                  p_next = ~^end_reg;
                  state_next = H_SEND;
               end
               else if (cfg_reg && step_reg == 2'h1)
               begin
                  step_next = 2'h2;
                  a_next = base + 32'(OFF_INTERLEAVE);
                  d_next = ilv_word; // R02
                  p_next = ~^ilv_word;
                  state_next = H_SEND;
               end
               else if (cfg_reg)
                  chain_next = end_reg; // R04
            end
         end
         default: state_next = H_IDLE;
      endcase
   end

   assign lnk.req_valid = (state_reg == H_SEND);
   assign lnk.req_write = w_reg;
   assign lnk.req_size = sz_reg;
   assign lnk.req_addr = a_reg;
   assign lnk.req_wdata = d_reg;
   assign lnk.req_wpar = p_reg;

   // ------------------------------------------------------------
   // APB registers
   // ------------------------------------------------------------
   always_comb
   begin
      node_next = node_reg;
      dens_next = dens_reg;
      set_next = set_reg;
      raw_addr_next = raw_addr_reg;
      raw_wdata_next = raw_wdata_reg;
      if (wr)
      begin
         case (paddr)
            APB_NODE: node_next = pwdata[3:0];
            APB_DENSITY: dens_next = pwdata;
            APB_SET: set_next = pwdata[7:0];
            APB_RAW_ADDR: raw_addr_next = pwdata;
            APB_RAW_WDATA: raw_wdata_next = pwdata;
            default: node_next = node_reg;
         endcase
      end
      prdata_next = prdata;
      if (rd)
      begin
         case (paddr)
            APB_CTRL: prdata_next = 32'(ctrl_reg);
            APB_NODE: prdata_next = 32'(node_reg);
            APB_DENSITY: prdata_next = dens_reg;
            APB_SET: prdata_next = 32'(set_reg);
            APB_RAW_ADDR: prdata_next = raw_addr_reg;
            APB_RAW_WDATA: prdata_next = raw_wdata_reg;
            APB_RAW_RDATA: prdata_next = raw_rdata_reg;
            APB_STATUS: prdata_next = {28'h0, err_reg, lnk.st_fail,
               lnk.st_done, state_reg != H_IDLE};
            APB_NEXT_START: prdata_next = chain_reg;
            default: prdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg <= H_IDLE;
         step_reg <= 2'h0;
         cfg_reg <= 1'b0;
         node_reg <= 4'h0;
         dens_reg <= '0;
         set_reg <= 8'h0;
         raw_addr_reg <= '0;
         raw_wdata_reg <= '0;
         raw_rdata_reg <= '0;
         chain_reg <= '0;
         end_reg <= '0;
         ctrl_reg <= 8'h0;
         err_reg <= 1'b0;
         a_reg <= '0;
         d_reg <= '0;
         w_reg <= 1'b0;
         p_reg <= 1'b0;
         sz_reg <= SIZE_LONG;
         prdata <= '0;
      end
      else
      begin
         state_reg <= state_next;
         step_reg <= step_next;
         cfg_reg <= cfg_next;
         node_reg <= node_next;
         dens_reg <= dens_next;
         set_reg <= set_next;
         raw_addr_reg <= raw_addr_next;
         raw_wdata_reg <= raw_wdata_next;
         raw_rdata_reg <= raw_rdata_next;
         chain_reg <= chain_next;
         end_reg <= end_next;
         ctrl_reg <= ctrl_next;
         err_reg <= err_next;
         a_reg <= a_next;
         d_reg <= d_next;
         w_reg <= w_next;
         p_reg <= p_next;
         sz_reg <= sz_next;
         prdata <= prdata_next;
      end
   end
endmodule : mn_host
`default_nettype wire

// File: testbench/mn_link_props.sv
// Link protocol checker
`default_nettype none
module mn_link_props
   import mn_pkg::*;
#(
   parameter logic [3:0] NODE = 4'h3
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Link signals
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [1:0] req_size,
   input wire logic [31:0] req_addr,
   input wire logic [31:0] req_wdata,
   input wire logic req_wpar,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire logic rsp_err,
   input wire logic st_req,
   input wire logic st_done
);
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   wire logic tk = req_valid & req_ready
      & (req_addr[31:15] == CSR_BASE[31:15] + 17'(NODE));
   a_answer_next: assert property (tk |=> rsp_valid)
      else $error("no answer");
   a_pulse_one: assert property (rsp_valid |=> !rsp_valid)
      else $error("long answer");
   a_size_err: assert property (tk & req_size != SIZE_LONG |=> rsp_err)
      else $error("size accepted");
   a_parity_err: assert property
      (tk & req_write & !(^{req_wdata, req_wpar}) |=> rsp_err)
      else $error("parity accepted");
   a_offset_err: assert property
      (tk & (req_addr[14:7] != 0 | req_addr[1:0] != 0) |=> rsp_err)
      else $error("offset accepted");
   a_test_start: assert property
      (st_req & req_ready |=> !st_done & !req_ready)
      else $error("test not started");
   a_test_length: assert property
      ($fell(st_done) |-> ##[120:140] st_done) else $error("test too long");
   a_test_quiet: assert property
      (!req_ready & !$past(req_ready) |-> !rsp_valid)
      else $error("answer in test");
   a_ready_done: assert property ($rose(st_done) |-> req_ready)
      else $error("done while busy");
endmodule : mn_link_props
`default_nettype wire

// File: testbench/test_memory_node_csr_and_address_map.sv
// Configurator and node bench
`default_nettype none
module test_memory_node_csr_and_address_map import mn_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
   logic mem_valid = 0, pready, pslverr, mem_hit, st_led;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, mem_addr = 32'h0, rd;
   logic [31:0] lf = 32'ha3d261d9;
   logic [7:0] cs [4] = '{8'h8c, 8'hac, 8'h0c, 8'h4c};
   int err_total = 0, checked = 0, dens, a;
   int mdl [32];
   mn_link_if lnk ();
   mn_node i_mn_node (.clk(clk), .nrst(nrst), .lnk(lnk), .node_id(4'h3),
      .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_hit(mem_hit),
      .st_led(st_led));
   mn_host i_mn_host (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lnk(lnk));
   mn_link_props #(.NODE(4'h3)) u_props (.clk(clk), .nrst(nrst),
      .req_valid(lnk.req_valid), .req_write(lnk.req_write),
      .req_size(lnk.req_size), .req_addr(lnk.req_addr),
      .req_wdata(lnk.req_wdata), .req_wpar(lnk.req_wpar),
      .req_ready(lnk.req_ready), .rsp_valid(lnk.rsp_valid),
      .rsp_err(lnk.rsp_err), .st_req(lnk.st_req), .st_done(lnk.st_done));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   initial forever #4 clk = ~clk;
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   task automatic chk(input string n, input logic [31:0] e, g);
      checked++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] ad,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic idle();
      do apb(1'b0, APB_STATUS, 0); while (rd[1:0] !== 2'b10);
   endtask : idle
   task automatic raw(input logic [7:0] c, o, input logic [31:0] d);
      apb(1'b1, APB_RAW_ADDR, {24'h0, o});
      apb(1'b1, APB_RAW_WDATA, d);
      apb(1'b1, APB_CTRL, {24'h0, c});
      idle();
      apb(1'b0, APB_RAW_RDATA, 0);
   endtask : raw
   task automatic complete_run();
      $display("Checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial
   begin
      #200us;
      err_total++;
      complete_run();
   end
   initial
   begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      idle();
      chk("led", 32'h1, 32'(st_led));
      lf = nxt(lf);
      dens = int'(lf[3:0]) + 1;
      apb(1'b1, APB_NODE, 32'h3);
      apb(1'b1, APB_DENSITY, dens);
      apb(1'b1, APB_SET, 32'h2);
      apb(1'b1, APB_CTRL, 32'h11);
      idle();
      mdl[21] = dens * 2;
      mdl[22] = 1;
      apb(1'b0, APB_NEXT_START, 0);
      chk("next", dens * 2, rd);
      for (int o = 'h50; o < 'h5c; o += 4)
      begin
         raw(8'h84, 8'(o), 0);
         chk("range", mdl[o / 4], rd);
      end
      raw(8'h84, 8'h00, 0);
      chk("ident", DEV_IDENT, rd);
      raw(8'h84, 8'h08, 0);
      apb(1'b0, APB_STATUS, 0);
      chk("unmapped", 32'h1, 32'(rd[3]));
      foreach (cs[j])
      begin
         lf = nxt(lf);
         raw(cs[j], 8'h14, lf);
         apb(1'b0, APB_STATUS, 0);
         chk("wr_err", 32'(cs[j] != 8'h8c), 32'(rd[3]));
         if (cs[j] == 8'h8c)
            mdl[5] = lf;
         raw(8'h84, 8'h14, 0);
         chk("ctl1", mdl[5], rd);
      end
      mem_valid <= 1'b1;
      repeat (12)
      begin
         lf = nxt(lf);
         a = int'(lf[23:0]);
         mem_addr <= 32'(a);
         @(negedge clk);
         chk("hit", 32'((a >> 18) < 2 * dens && a[5] == 0), 32'(mem_hit));
         @(posedge clk);
      end
      mem_valid <= 1'b0;
      apb(1'b1, APB_CTRL, 32'h02);
      idle();
      raw(8'h84, 8'h14, 0);
      chk("cleared", 32'h0, rd);
      complete_run();
   end
endmodule : test_memory_node_csr_and_address_map
`default_nettype wire
